// ---- arf_core.sv ----
// Result coding, gain, sign and temperature channel logic of a 10-bit converter.
// Assumes the analog core delivers a signed difference sample with a done strobe.
// What this block does
// - The result bytes hold the finished conversion once the done flag is set.
// - Single-ended results are vin*1024/vref, 0x000 at ground up to 0x3FF.
// - Unipolar differential results are unsigned 0x000..0x3FF, zero when negative exceeds positive.
// - Differential differences are scaled by a gain of 1, 8, 20 or 32 picked by gain_code and gain_high_range.
// - Differential mode is unipolar after reset and bipolar when the bipolar select bit is one.
// - Bipolar results are difference*512/vref in two's complement from 0x200 to 0x1FF.
// - In bipolar mode bit 9, in the high byte, is one for negative and zero for positive.
// - Selection all ones enables the temperature sensor and routes it as the input.
// - Changing left adjust re-presents the result bytes at the next enabled clock, mid conversion or not.
// - The result is stored and the done flag set in the same cycle a conversion ends.
`timescale 1ns/1ps
`default_nettype none
`include "arf_defs.svh"
module arf_core (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Control bits
   input wire logic [5:0] channel_gain_select,
   input wire logic bipolar_select,
   input wire logic left_adjust_select,
   input wire logic differential_channel,
   input wire logic gain_high_range,
   input wire logic [1:0] gain_code,
   input wire logic done_flag_clear,
   // Analog core sample: signed difference in units of vref/1024
   input wire logic sample_valid,
   input wire logic signed [15:0] sample_value,
   // Outputs
   output logic [7:0] result_low_byte,
   output logic [7:0] result_high_byte,
   output logic conversion_done_flag,
   output logic temperature_sensor_enable,
   output logic temperature_channel
);
   // Stored result and its presentation
   logic [9:0] result_reg;
   logic [9:0] result_next;
   logic [9:0] present_src;
   logic take_sample;
   logic temp_selected;
   logic signed [21:0] scaled;
   logic signed [21:0] half;
   logic [1:0] gsel;
   arf_pkg::arf_mode_t mode;
   arf_pkg::arf_result_t shown;

   // Gain code after the range stage: high range turns 1x/20x into 8x/32x
   function automatic logic [1:0] pick_gain(input logic high_range,
                                            input logic [1:0] code);
      if (high_range) begin
         pick_gain = {code[1], 1'b1};
      end else begin
         pick_gain = code;
      end
   endfunction

   // Gain multiplier: the range-adjusted code gsel picks 1x, 8x, 20x or 32x
   function automatic logic signed [21:0] apply_gain(input logic signed [15:0] d,
                                                     input logic [1:0] g);
      logic signed [21:0] w;
      w = 22'(d);
      unique case (g)
         `ARF_GAIN_1: apply_gain = w;
         `ARF_GAIN_8: apply_gain = w <<< 3;
         `ARF_GAIN_20: apply_gain = (w <<< 4) + (w <<< 2);
         `ARF_GAIN_32: apply_gain = w <<< 5;
      endcase
   endfunction

   // Clamp to an unsigned 10-bit code
   function automatic logic [9:0] clamp_unsigned(input logic signed [21:0] v);
      if (v < 0)
         clamp_unsigned = `ARF_CODE_ZERO;
      else if (v > 22'sd1023)
         clamp_unsigned = `ARF_CODE_MAX;
      else
         clamp_unsigned = v[9:0];
   endfunction

   // Clamp to a two's complement 10-bit code
   function automatic logic [9:0] clamp_signed(input logic signed [21:0] v);
      if (v > 22'sh1FF) begin
         clamp_signed = `ARF_BIP_MAX;
      end else if (v < -22'sh200) begin
         clamp_signed = `ARF_BIP_MIN;
      end else begin
         clamp_signed = v[9:0];
      end
   endfunction

   // Byte placement of a 10-bit result
   function automatic arf_pkg::arf_result_t format_result(input logic [9:0] r,
                                                          input logic left);
      arf_pkg::arf_result_t f;
      if (left) begin
         f.result_high_byte = r[9:2];
         f.result_low_byte = {r[1:0], 6'h00};
      end else begin
         f.result_high_byte = {6'h00, r[9:8]};
         f.result_low_byte = r[7:0];
      end
      format_result = f;
   endfunction

   // Temperature channel decode
   function automatic logic is_temp_select(input logic [5:0] sel);
      is_temp_select = (sel == `ARF_TEMP_SEL);
   endfunction

   // Input mode
   always_comb begin
      if (!differential_channel) begin
         mode = arf_pkg::ARF_SINGLE;
      end else if (bipolar_select) begin
         mode = arf_pkg::ARF_BIPOLAR;
      end else begin
         mode = arf_pkg::ARF_UNIPOLAR;
      end
   end

   // Differential gain path
   always_comb begin
      gsel = pick_gain(gain_high_range, gain_code);
      scaled = apply_gain(sample_value, gsel);
      half = scaled >>> 1;
   end

   // Result coding per mode
   always_comb begin
      result_next = `ARF_CODE_ZERO;
      unique case (mode)
         arf_pkg::ARF_SINGLE: begin
            result_next = clamp_unsigned(22'(sample_value));
         end
         arf_pkg::ARF_UNIPOLAR: begin
            result_next = clamp_unsigned(scaled);
         end
         arf_pkg::ARF_BIPOLAR: begin
            result_next = clamp_signed(half);
         end
         default: begin
            result_next = `ARF_CODE_ZERO;
         end
      endcase
   end

   // A finished sample reaches the bytes in the same cycle the done flag rises
   assign take_sample = clk_en && sample_valid;
   assign temp_selected = is_temp_select(channel_gain_select);

   always_comb begin
      if (take_sample) begin
         present_src = result_next;
      end else begin
         present_src = result_reg;
      end
   end

   // Adjustment follows the live bit; registered outputs show a change one clock later
   always_comb begin
      shown = format_result(present_src, left_adjust_select);
   end

   // Stored result, kept so the bytes can be re-presented when the adjust bit moves
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         result_reg <= `ARF_CODE_ZERO;
      end else if (take_sample) begin
         result_reg <= result_next;
      end
   end

   // Done flag: set wins over a clear in the same cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         conversion_done_flag <= 1'b0;
      end else if (clk_en) begin
         if (sample_valid) begin
            conversion_done_flag <= 1'b1;
         end else if (done_flag_clear) begin
            conversion_done_flag <= 1'b0;
         end
      end
   end

   // Low result byte
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         result_low_byte <= 8'h00;
      end else if (clk_en) begin
         result_low_byte <= shown.result_low_byte;
      end
   end

   // High result byte, carrying the sign in bipolar mode
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         result_high_byte <= 8'h00;
      end else if (clk_en) begin
         result_high_byte <= shown.result_high_byte;
      end
   end

   // Temperature sensor enable
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         temperature_sensor_enable <= 1'b0;
      end else if (clk_en) begin
         temperature_sensor_enable <= temp_selected;
      end
   end

   // Temperature channel routing
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         temperature_channel <= 1'b0;
      end else if (clk_en) begin
         temperature_channel <= temp_selected;
      end
   end
endmodule
`default_nettype wire

// ---- arf_defs.svh ----
// Constants for the converter result formatting block.
// Assumes inclusion by the package and the design module only.
`ifndef ARF_DEFS_SVH
`define ARF_DEFS_SVH
`define ARF_RES_W 10
`define ARF_SEL_W 6
`define ARF_CODE_MAX 10'h3FF
`define ARF_CODE_ZERO 10'h000
`define ARF_BIP_MAX 10'h1FF
`define ARF_BIP_MIN 10'h200
`define ARF_TEMP_SEL 6'h3F
`define ARF_GAIN_1 2'h0
`define ARF_GAIN_8 2'h1
`define ARF_GAIN_20 2'h2
`define ARF_GAIN_32 2'h3
`endif

// ---- arf_pkg.sv ----
// Types for the converter result formatting block.
// Assumes arf_defs.svh is on the include path.
`include "arf_defs.svh"
package arf_pkg;
   typedef enum logic [1:0] {
      ARF_SINGLE = 2'b00,
      ARF_UNIPOLAR = 2'b01,
      ARF_BIPOLAR = 2'b10
   } arf_mode_t;
   typedef struct packed {
      logic [7:0] result_low_byte;
      logic [7:0] result_high_byte;
   } arf_result_t;
endpackage

// ---- arf_core_asserts.sv ----
// Port checks for the result formatting block.
// Assumes one clock domain; bound onto every arf_core.
`timescale 1ns/1ps
`default_nettype none
module arf_core_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Inputs
   input wire logic clk_en,
   input wire logic [5:0] channel_gain_select,
   input wire logic bipolar_select,
   input wire logic left_adjust_select,
   input wire logic differential_channel,
   input wire logic done_flag_clear,
   input wire logic sample_valid,
   input wire logic signed [15:0] sample_value,
   // Outputs
   input wire logic [7:0] result_low_byte,
   input wire logic [7:0] result_high_byte,
   input wire logic conversion_done_flag,
   input wire logic temperature_sensor_enable
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   chk_done_set: assert property (clk_en && sample_valid |=> conversion_done_flag)
      else $error("done flag not set");
   chk_done_hold: assert property (clk_en && conversion_done_flag && !done_flag_clear
      |=> conversion_done_flag)
      else $error("done flag lost");
   chk_done_clear: assert property (clk_en && done_flag_clear && !sample_valid
      |=> !conversion_done_flag)
      else $error("done flag not cleared");
   chk_right_adj: assert property ($past(clk_en && !left_adjust_select)
      |-> result_high_byte[7:2] == 6'h00)
      else $error("right adjust high bits set");
   chk_left_adj: assert property ($past(clk_en && left_adjust_select)
      |-> result_low_byte[5:0] == 6'h00)
      else $error("left adjust low bits set");
   chk_temp_sel: assert property ($past(clk_en) |->
      temperature_sensor_enable == ($past(channel_gain_select) == 6'h3F))
      else $error("sensor enable wrong");
   chk_result_hold: assert property ($past(clk_en) && !sample_valid
      && $stable(left_adjust_select) |=> $stable({result_high_byte, result_low_byte}))
      else $error("result moved");
   chk_uni_zero: assert property (clk_en && sample_valid && differential_channel
      && !bipolar_select && sample_value < 16'sh0000
      |=> {result_high_byte, result_low_byte} == 16'h0000)
      else $error("unipolar negative not zero");
   chk_bip_sign: assert property (clk_en && sample_valid && differential_channel
      && bipolar_select && sample_value < 16'sh0000 && !left_adjust_select
      |=> result_high_byte[1])
      else $error("sign bit clear");
endmodule
bind arf_core arf_core_asserts arf_core_asserts_i (.*);
`default_nettype wire

// ---- arf_core_tb.sv ----
// Bench for the result formatting block.
// Assumes arf_pkg, arf_core and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module arf_core_tb;
   logic clk = 0, sys_rst = 1, clk_en = 1, sv = 0, bs = 0, la = 0, dc = 0, hr = 0, clr = 0;
   logic [5:0] sel = 6'h00;
   logic [1:0] gc = 2'h0;
   logic signed [15:0] smp = 16'h0000;
   logic [7:0] lo, hi;
   logic done, ten, tch;
   int num_errors = 0, n_compared = 0, cyc = 0;
   int gv[4] = '{1, 8, 20, 32};
   arf_core arf_core_i (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .channel_gain_select(sel), .bipolar_select(bs), .left_adjust_select(la),
      .differential_channel(dc), .gain_high_range(hr), .gain_code(gc), .done_flag_clear(clr),
      .sample_valid(sv), .sample_value(smp), .result_low_byte(lo), .result_high_byte(hi),
      .conversion_done_flag(done), .temperature_sensor_enable(ten), .temperature_channel(tch));
   initial forever #50 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 500) begin
         num_errors++;
         test_done;
      end
   end
   task tick;
      @(posedge clk);
      #1;
   endtask
   task cmp(input string n, input logic [15:0] e, a);
      n_compared++;
      if (a !== e) begin
         $display("ERROR %s exp %h got %h", n, e, a);
         num_errors++;
      end
   endtask
   function logic [9:0] ex(int s, d, b, g);
      int k;
      k = d ? s * gv[g] / (b ? 2 : 1) : s;
      if (b) k = k > 511 ? 511 : (k < -512 ? -512 : k);
      else k = k > 1023 ? 1023 : (k < 0 ? 0 : k);
      return k[9:0];
   endfunction
   task conv(int s, d, b, g);
      smp = 16'(s);
      dc = 1'(d);
      bs = 1'(b);
      gc = 2'(g);
      hr = 1'(g);
      sv = 1;
      tick;
      sv = 0;
      cmp("done", 16'h0001, {15'h0000, done});
      tick;
      cmp("right", {6'h00, ex(s, d, b, g)}, {hi, lo});
      la = 1;
      tick;
      cmp("left", {ex(s, d, b, g), 6'h00}, {hi, lo});
      la = 0;
      clr = 1;
      tick;
      clr = 0;
      cmp("clear", 16'h0000, {15'h0000, done});
      tick;
      $display("conversion test done");
   endtask
   task freeze_race;
      clk_en = 0;
      smp = 16'h0064;
      dc = 0;
      bs = 0;
      sv = 1;
      tick;
      cmp("frozen done", 16'h0000, {15'h0000, done});
      cmp("frozen bytes", {6'h00, ex(300, 0, 0, 0)}, {hi, lo});
      clk_en = 1;
      clr = 1;
      tick;
      sv = 0;
      clr = 0;
      cmp("set wins", 16'h0001, {15'h0000, done});
      cmp("unfrozen", {6'h00, ex(100, 0, 0, 0)}, {hi, lo});
      clr = 1;
      tick;
      clr = 0;
      tick;
      $display("freeze test done");
   endtask
   task test_done;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      #1 sys_rst = 0;
      tick;
      conv(1023, 0, 0, 0);
      conv(5, 0, 0, 0);
      for (int g = 0; g < 4; g++) conv(12, 1, 0, g);
      conv(-7, 1, 0, 3);
      conv(40, 1, 0, 3);
      conv(-100, 1, 1, 0);
      conv(2000, 1, 1, 3);
      conv(-2000, 1, 1, 2);
      sel = 6'h3F;
      tick;
      tick;
      cmp("sensor on", 16'h0003, {14'h0000, ten, tch});
      conv(300, 0, 0, 0);
      sel = 6'h00;
      tick;
      tick;
      cmp("sensor off", 16'h0000, {14'h0000, ten, tch});
      $display("sensor test done");
      freeze_race;
      test_done;
   end
endmodule
`default_nettype wire
